/* File: core/pfb_brake_ctrl.sv */
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module pfb_brake_ctrl import pfb_pkg::*; #(
    parameter int CHANNELS = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,

    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,

    // Brake sources
    input wire logic brake_pin,
    input wire logic adc_cmp_event,

    // From the counter core
    input wire logic [CHANNELS-1:0] pg,
    input wire logic cnt_top,
    input wire logic cnt_end,

    // To the counter core
    output logic run,
    output logic counter_clear,
    output logic load_strobe,
    output logic center_mode,
    output logic [1:0] output_mode,
    output logic group_mode,
    output logic [2:0] prescale,

    // Pins and interrupt requests
    output logic [CHANNELS-1:0] pwm_out,
    output logic period_point_flag,
    output logic brake_irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic run_enable;
        logic load_pend;
        logic period_point_flag;
        logic counter_clear;
        logic load_strobe;
        logic [1:0] output_mode;
        logic group_mode;
        logic alignment_type_select;
        logic brake_input_enable;
        logic [2:0] prescale;
        logic brake_flag;
        logic brake_input_level_select;
        logic [CHANNELS-1:0] brake_levels_reg;
        logic brake_active;
        logic [CHANNELS-1:0] channel_polarity_bits;
        logic [2:0] irq_channel_select;
        logic [1:0] irq_point_type;
        logic brake_irq_enable;
        logic pin_q;
        logic [CHANNELS-1:0] pwm_out;
        logic brake_irq;
        logic [7:0] rdata;
    } pfb_state_t;

    pfb_state_t st, next_st;

    logic pin_level;
    logic point_hit;
    logic pin_edge;
    logic brake_event;
    logic run_wr;
    logic brake_wr;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    pfb_pin_filter #(
        .STABLE_CYCLES(DEBOUNCE_CYCLES)
    ) u_filter (
        .clk(clk),
        .rst_n(rst_n),
        .pin(brake_pin),
        .level(pin_level)
    );

    pfb_point_detect #(
        .CHANNELS(CHANNELS)
    ) u_point (
        .clk(clk),
        .rst_n(rst_n),
        .chan_sel(st.irq_channel_select),
        .point_type(st.irq_point_type),
        .center_mode(st.alignment_type_select),
        .pg(pg),
        .cnt_top(cnt_top),
        .cnt_end(cnt_end),
        .hit(point_hit)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.pin_q = pin_level;
        run_wr = wr && (addr == RUN_CTRL_ADDR);
        brake_wr = wr && (addr == BRAKE_DATA_ADDR);

        // Level 1 selects a rising edge, 0 a falling edge
        pin_edge = (pin_level != st.pin_q)
            && (pin_level == st.brake_input_level_select);
        // Gate on the edge only, so enabling while the pin sits active does not brake
        brake_event = (pin_edge && st.brake_input_enable)
            || adc_cmp_event;

        // Single-cycle strobes fall back by default
        next_st.counter_clear = 1'b0;
        next_st.load_strobe = 1'b0;

        // Register writes
        if (run_wr) begin
            next_st.run_enable = wdata[RUN_BIT];
            if (wdata[RUN_BIT]) begin
                next_st.brake_active = 1'b0;
            end
            if (wdata[LOAD_BIT]) begin
                next_st.load_pend = 1'b1;
            end
            if (!wdata[PFLAG_BIT]) begin
                next_st.period_point_flag = 1'b0;
            end
            if (wdata[CLR_BIT]) begin
                next_st.counter_clear = 1'b1;
            end
        end
        if (wr && addr == MODE_CTRL_ADDR) begin
            next_st.output_mode = wdata[MODE_LSB +: 2];
            next_st.group_mode = wdata[GROUP_BIT];
            next_st.alignment_type_select = wdata[ALIGN_BIT];
            next_st.brake_input_enable = wdata[FBEN_BIT];
            next_st.prescale = wdata[PRESCALE_LSB +: 3];
        end
        if (brake_wr) begin
            next_st.brake_levels_reg = wdata[CHANNELS-1:0];
            next_st.brake_input_level_select = wdata[BLSEL_BIT];
            // Writing 1 to the flag does nothing; only a 0 clears it
            if (!wdata[BFLAG_BIT]) begin
                next_st.brake_flag = 1'b0;
            end
        end
        if (wr && addr == POLARITY_ADDR) begin
            next_st.channel_polarity_bits = wdata[CHANNELS-1:0];
        end
        if (wr && addr == IRQ_CTRL_ADDR) begin
            next_st.irq_channel_select = wdata[ISEL_LSB +: 3];
            next_st.irq_point_type = wdata[ITYPE_LSB +: 2];
        end
        if (wr && addr == EXT_IRQ_EN_ADDR) begin
            next_st.brake_irq_enable = wdata[BRAKE_IE_BIT];
        end

        // Load completes at the end of the current period
        if (st.load_pend && cnt_end) begin
            next_st.load_pend = 1'b0;
            next_st.load_strobe = 1'b1;
        end

        // Hardware sets win over software clears
        if (point_hit) begin
            next_st.period_point_flag = 1'b1;
        end

        // Brake last, so it beats a same-cycle run write
        if (brake_event) begin
            next_st.brake_active = 1'b1;
            next_st.run_enable = 1'b0;
            next_st.counter_clear = 1'b1;
            next_st.brake_flag = 1'b1;
        end

        // Outputs: brake override then polarity
        for (int i = 0; i < CHANNELS; i++) begin
            next_st.pwm_out[i] = (next_st.brake_active ? next_st.brake_levels_reg[i]
                : (pg[i] & next_st.run_enable))
                ^ next_st.channel_polarity_bits[i];
        end
        next_st.brake_irq = next_st.brake_flag && next_st.brake_irq_enable;

        // Read data, one cycle after the strobe; unmapped reads zero
        next_st.rdata = 8'h00;
        if (rd) begin
            case (addr)
                RUN_CTRL_ADDR: begin
                    next_st.rdata[RUN_BIT] = st.run_enable;
                    next_st.rdata[LOAD_BIT] = st.load_pend;
                    next_st.rdata[PFLAG_BIT] = st.period_point_flag;
                    next_st.rdata[CLR_BIT] = st.counter_clear;
                end
                MODE_CTRL_ADDR: begin
                    next_st.rdata[MODE_LSB +: 2] = st.output_mode;
                    next_st.rdata[GROUP_BIT] = st.group_mode;
                    next_st.rdata[ALIGN_BIT] = st.alignment_type_select;
                    next_st.rdata[FBEN_BIT] = st.brake_input_enable;
                    next_st.rdata[PRESCALE_LSB +: 3] = st.prescale;
                end
                BRAKE_DATA_ADDR: begin
                    next_st.rdata[BFLAG_BIT] = st.brake_flag;
                    next_st.rdata[BLSEL_BIT] = st.brake_input_level_select;
                    next_st.rdata[CHANNELS-1:0] = st.brake_levels_reg;
                end
                POLARITY_ADDR: begin
                    next_st.rdata[CHANNELS-1:0] = st.channel_polarity_bits;
                end
                IRQ_CTRL_ADDR: begin
                    next_st.rdata[ISEL_LSB +: 3] = st.irq_channel_select;
                    next_st.rdata[ITYPE_LSB +: 2] = st.irq_point_type;
                end
                EXT_IRQ_EN_ADDR: begin
                    next_st.rdata[BRAKE_IE_BIT] = st.brake_irq_enable;
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
            st.channel_polarity_bits <= CHAN_RESET;
            st.rdata <= DATA_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from state
    // ------------------------------------------------------------
    assign rdata = st.rdata;
    assign run = st.run_enable;
    assign counter_clear = st.counter_clear;
    assign load_strobe = st.load_strobe;
    assign center_mode = st.alignment_type_select;
    assign output_mode = st.output_mode;
    assign group_mode = st.group_mode;
    assign prescale = st.prescale;
    assign pwm_out = st.pwm_out;
    assign period_point_flag = st.period_point_flag;
    assign brake_irq = st.brake_irq;

endmodule

/* File: core/pfb_pkg.sv */
package pfb_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] RUN_CTRL_ADDR = 8'hD7;
    localparam logic [7:0] MODE_CTRL_ADDR = 8'hD8;
    localparam logic [7:0] BRAKE_DATA_ADDR = 8'hD9;
    localparam logic [7:0] POLARITY_ADDR = 8'hDA;
    localparam logic [7:0] IRQ_CTRL_ADDR = 8'hDB;
    localparam logic [7:0] EXT_IRQ_EN_ADDR = 8'hDC;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RUN_BIT = 7;
    localparam int LOAD_BIT = 6;
    localparam int PFLAG_BIT = 5;
    localparam int CLR_BIT = 4;
    localparam int MODE_LSB = 6;
    localparam int GROUP_BIT = 5;
    localparam int ALIGN_BIT = 4;
    localparam int FBEN_BIT = 3;
    localparam int PRESCALE_LSB = 0;
    localparam int BFLAG_BIT = 7;
    localparam int BLSEL_BIT = 6;
    localparam int ISEL_LSB = 0;
    localparam int ITYPE_LSB = 4;
    localparam int BRAKE_IE_BIT = 5;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] RUN_CTRL_RESET = 8'h00;
    localparam logic [5:0] CHAN_RESET = 6'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam int DEBOUNCE_CYCLES = 8;

    // Period point types
    localparam logic [1:0] PT_FALL = 2'h0;
    localparam logic [1:0] PT_RISE = 2'h1;
    localparam logic [1:0] PT_CENTER = 2'h2;
    localparam logic [1:0] PT_END = 2'h3;

endpackage

/* File: core/pfb_pin_filter.sv */
`timescale 1ns/1ps
module pfb_pin_filter import pfb_pkg::*; #(
    parameter int STABLE_CYCLES = DEBOUNCE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Raw pin and filtered level
    input wire logic pin,
    output logic level
);

    typedef struct packed {
        logic [2:0] sync;
        logic [3:0] count;
        logic level;
    } pfb_filt_t;

    pfb_filt_t st, next_st;

    // ------------------------------------------------------------
    // Three-stage sync, then stability counter
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.sync = {st.sync[1:0], pin};
        // Only stages two and three are compared; stage one is metastable
        if (st.sync[1] != st.sync[2] || st.sync[2] == st.level) begin
            next_st.count = 4'h0;
        end else if (st.count == 4'(STABLE_CYCLES - 1)) begin
            next_st.level = st.sync[2];
            next_st.count = 4'h0;
        end else begin
            next_st.count = st.count + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.level;

endmodule

/* File: core/pfb_point_detect.sv */
`timescale 1ns/1ps
module pfb_point_detect import pfb_pkg::*; #(
    parameter int CHANNELS = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Selection
    input wire logic [2:0] chan_sel,
    input wire logic [1:0] point_type,
    input wire logic center_mode,
    // Generator status
    input wire logic [CHANNELS-1:0] pg,
    input wire logic cnt_top,
    input wire logic cnt_end,
    // One-cycle hit
    output logic hit
);

    typedef struct packed {
        logic [CHANNELS-1:0] pg_q;
        logic hit;
    } pfb_point_t;

    pfb_point_t st, next_st;
    logic cur, prev, valid;

    always_comb begin
        next_st = st;
        next_st.pg_q = pg;
        valid = (int'(chan_sel) < CHANNELS);
        cur = valid ? pg[chan_sel] : 1'b0;
        prev = valid ? st.pg_q[chan_sel] : 1'b0;
        case (point_type)
            PT_FALL: next_st.hit = prev & ~cur;
            PT_RISE: next_st.hit = ~prev & cur;
            PT_CENTER: next_st.hit = center_mode & cnt_top;
            PT_END: next_st.hit = center_mode & cnt_end;
            default: next_st.hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign hit = st.hit;

endmodule

/* File: bench/pfb_brake_checker.sv */
`timescale 1ns/1ps
module pfb_brake_checker import pfb_pkg::*; #(
    parameter int CHANNELS = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // Events and outputs
    input wire logic adc_cmp_event,
    input wire logic cnt_end,
    input wire logic run,
    input wire logic counter_clear,
    input wire logic load_strobe,
    input wire logic [CHANNELS-1:0] pwm_out,
    input wire logic period_point_flag,
    input wire logic brake_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_run_write;
        wr && addr == RUN_CTRL_ADDR && wdata[RUN_BIT];
    endsequence
    sequence s_brake_done;
        !run && counter_clear;
    endsequence

    a_adc_brake: assert property (adc_cmp_event |=> s_brake_done)
        else $error("compare event did not brake");
    a_run_resume: assert property (s_run_write ##0 !adc_cmp_event |=> run)
        else $error("run write did not start");
    a_clr_write: assert property (
        wr && addr == RUN_CTRL_ADDR && wdata[CLR_BIT] |=> ##[0:1] counter_clear)
        else $error("clear write gave no pulse");
    a_load_end: assert property (load_strobe |-> $past(cnt_end))
        else $error("load strobe outside period end");
    // Braked or idle outputs may only move after a write or a new brake
    a_brake_steady: assert property (
        !run && !$past(run) && !counter_clear && !$past(wr) && !$past(wr, 2)
        |-> $stable(pwm_out))
        else $error("braked outputs moved");
    a_irq_cause: assert property (
        $rose(brake_irq) |-> counter_clear || $past(counter_clear) || $past(wr) || $past(wr, 2))
        else $error("brake irq without cause");
    a_pflag_sticky: assert property (
        $fell(period_point_flag) |-> $past(wr) || $past(wr, 2))
        else $error("period flag fell by itself");
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside its cycle");
endmodule

bind pfb_brake_ctrl pfb_brake_checker #(.CHANNELS(CHANNELS)) pfb_brake_checker_i (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .adc_cmp_event(adc_cmp_event), .cnt_end(cnt_end), .run(run),
    .counter_clear(counter_clear), .load_strobe(load_strobe), .pwm_out(pwm_out),
    .period_point_flag(period_point_flag), .brake_irq(brake_irq)
);

/* File: bench/pfb_fault_source.sv */
`timescale 1ns/1ps
module pfb_fault_source import pfb_pkg::*; #(
    parameter int PERIOD = 16
) (
    // Clock
    input wire logic clk,
    // Core controls from the block
    input wire logic run,
    input wire logic counter_clear,
    // Fault pin and generator status
    output logic brake_pin,
    output logic [5:0] pg,
    output logic cnt_top,
    output logic cnt_end
);
    logic [15:0] cnt = 16'h0000;

    initial brake_pin = 1'b0;

    // Edge-type counter only; center slope not modelled
    always @(posedge clk) begin
        if (counter_clear) begin
            cnt <= 16'h0000;
        end else if (run) begin
            cnt <= (cnt == 16'(PERIOD - 1)) ? 16'h0000 : cnt + 16'h0001;
        end
    end

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            pg[i] = run && (cnt < 16'(2 * i + 2));
        end
        cnt_top = run && (cnt == 16'(PERIOD / 2));
        cnt_end = run && (cnt == 16'(PERIOD - 1));
    end

    // Pin request held whole cycles, then returned to idle
    task automatic drive(input logic lvl, input int cycles);
        @(posedge clk);
        brake_pin <= lvl;
        repeat (cycles) @(posedge clk);
        brake_pin <= ~lvl;
        #1;
    endtask
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb import pfb_pkg::*; ();
    localparam int PERIOD = 16;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic adc_cmp_event = 1'b0;
    logic [7:0] rdata;
    logic brake_pin, cnt_top, cnt_end, run, counter_clear, load_strobe, center_mode;
    logic [5:0] pg, pwm_out;
    logic period_point_flag, brake_irq, hit;
    logic [1:0] output_mode;
    logic group_mode;
    logic [2:0] prescale;
    logic [5:0] pol = 6'h05;
    logic [5:0] p;
    logic [7:0] rv;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;

    pfb_brake_ctrl #(.CHANNELS(6)) pfb_brake_ctrl_i (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .brake_pin(brake_pin), .adc_cmp_event(adc_cmp_event), .pg(pg),
        .cnt_top(cnt_top), .cnt_end(cnt_end), .run(run), .counter_clear(counter_clear),
        .load_strobe(load_strobe), .center_mode(center_mode), .output_mode(output_mode),
        .group_mode(group_mode), .prescale(prescale), .pwm_out(pwm_out),
        .period_point_flag(period_point_flag), .brake_irq(brake_irq)
    );
    pfb_fault_source #(.PERIOD(PERIOD)) pfb_fault_source_i (
        .clk(clk), .run(run), .counter_clear(counter_clear), .brake_pin(brake_pin),
        .pg(pg), .cnt_top(cnt_top), .cnt_end(cnt_end)
    );

    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            failures = failures + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (failures == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic follow(input string name);
        repeat (PERIOD) begin
            p = pg;
            tick(1);
            check(name, 8'(pwm_out), 8'(p ^ pol));
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd_reg(RUN_CTRL_ADDR, rv);
        check("run_control", rv, RUN_CTRL_RESET);
        rd_reg(BRAKE_DATA_ADDR, rv);
        check("brake_data", rv, DATA_RESET);
        rd_reg(8'hE0, rv);
        check("unmapped", rv, 8'h00);
        check("idle_out", 8'(pwm_out), 8'(CHAN_RESET));
        wr_reg(MODE_CTRL_ADDR, 8'h65);
        check("mode_out", 8'({output_mode, group_mode, center_mode, prescale}), 8'h35);
        rd_reg(MODE_CTRL_ADDR, rv);
        check("mode_back", rv, 8'h65);
        wr_reg(MODE_CTRL_ADDR, 8'h00);
    endtask
    task automatic t_run();
        wr_reg(POLARITY_ADDR, 8'(pol));
        tick(1);
        check("idle_inverted", 8'(pwm_out), 8'(pol));
        wr_reg(RUN_CTRL_ADDR, 8'h80);
        tick(2);
        follow("normal_out");
    endtask
    task automatic t_adc();
        wr_reg(BRAKE_DATA_ADDR, 8'h2A);
        @(posedge clk);
        adc_cmp_event <= 1'b1;
        @(posedge clk);
        adc_cmp_event <= 1'b0;
        #1;
        check("adc_run", 8'(run), 8'h00);
        check("adc_clear", 8'(counter_clear), 8'h01);
        check("adc_levels", 8'(pwm_out), 8'(6'h2A ^ pol));
        check("irq_masked", 8'(brake_irq), 8'h00);
        rd_reg(BRAKE_DATA_ADDR, rv);
        check("flag_set", rv, 8'hAA);
        wr_reg(EXT_IRQ_EN_ADDR, 8'h20);
        tick(2);
        check("irq_on", 8'(brake_irq), 8'h01);
        wr_reg(BRAKE_DATA_ADDR, 8'h2A);
        tick(2);
        check("irq_off", 8'(brake_irq), 8'h00);
        check("still_braked", 8'(pwm_out), 8'(6'h2A ^ pol));
        wr_reg(RUN_CTRL_ADDR, 8'h80);
        tick(2);
        follow("resumed");
    endtask
    task automatic t_same();
        @(posedge clk);
        adc_cmp_event <= 1'b1;
        addr <= RUN_CTRL_ADDR;
        wdata <= 8'h80;
        wr <= 1'b1;
        @(posedge clk);
        adc_cmp_event <= 1'b0;
        wr <= 1'b0;
        tick(2);
        check("brake_wins", 8'(run), 8'h00);
    endtask
    task automatic t_pin();
        wr_reg(BRAKE_DATA_ADDR, 8'h6A);
        wr_reg(RUN_CTRL_ADDR, 8'h80);
        pfb_fault_source_i.drive(1'b1, 20);
        tick(16);
        check("pin_disabled", 8'(run), 8'h01);
        wr_reg(MODE_CTRL_ADDR, 8'h08);
        pfb_fault_source_i.drive(1'b1, 5);
        tick(16);
        check("pin_glitch", 8'(run), 8'h01);
        pfb_fault_source_i.drive(1'b1, 20);
        check("pin_rise", 8'(run), 8'h00);
        tick(16);
        wr_reg(BRAKE_DATA_ADDR, 8'h2A);
        wr_reg(RUN_CTRL_ADDR, 8'h80);
        pfb_fault_source_i.drive(1'b1, 20);
        check("pin_no_rise", 8'(run), 8'h01);
        tick(16);
        check("pin_fall", 8'(run), 8'h00);
        check("pin_levels", 8'(pwm_out), 8'(6'h2A ^ pol));
        wr_reg(RUN_CTRL_ADDR, 8'h80);
    endtask
    task automatic t_load();
        wr_reg(RUN_CTRL_ADDR, 8'h90);
        hit = 1'b0;
        repeat (2) begin
            hit = hit | counter_clear;
            tick(1);
        end
        check("clear_pulse", 8'(hit), 8'h01);
        wr_reg(RUN_CTRL_ADDR, 8'hC0);
        rd_reg(RUN_CTRL_ADDR, rv);
        check("load_pend", rv & 8'hD0, 8'hC0);
        for (int i = 0; i < 40 && !load_strobe; i++) tick(1);
        check("load_strobe", 8'(load_strobe), 8'h01);
        rd_reg(RUN_CTRL_ADDR, rv);
        check("load_done", rv & 8'h40, 8'h00);
    endtask
    task automatic t_flag();
        wr_reg(IRQ_CTRL_ADDR, 8'h10);
        wr_reg(RUN_CTRL_ADDR, 8'h80);
        for (int i = 0; i < 40 && !period_point_flag; i++) tick(1);
        check("pflag_rise", 8'(period_point_flag), 8'h01);
        tick(PERIOD);
        check("pflag_sticky", 8'(period_point_flag), 8'h01);
        wr_reg(IRQ_CTRL_ADDR, 8'h30);
        wr_reg(RUN_CTRL_ADDR, 8'h80);
        tick(2 * PERIOD);
        check("pflag_edge_type", 8'(period_point_flag), 8'h00);
        wr_reg(MODE_CTRL_ADDR, 8'h10);
        check("center_mode", 8'(center_mode), 8'h01);
        for (int i = 0; i < 40 && !period_point_flag; i++) tick(1);
        check("pflag_end", 8'(period_point_flag), 8'h01);
        rd_reg(IRQ_CTRL_ADDR, rv);
        check("irq_ctrl_back", rv, 8'h30);
        wr_reg(IRQ_CTRL_ADDR, 8'h20);
        wr_reg(RUN_CTRL_ADDR, 8'h80);
        for (int i = 0; i < 40 && !period_point_flag; i++) tick(1);
        check("pflag_center", 8'(period_point_flag), 8'h01);
        wr_reg(IRQ_CTRL_ADDR, 8'h02);
        wr_reg(RUN_CTRL_ADDR, 8'h80);
        for (int i = 0; i < 40 && !period_point_flag; i++) tick(1);
        check("pflag_fall", 8'(period_point_flag), 8'h01);
        wr_reg(IRQ_CTRL_ADDR, 8'h16);
        wr_reg(RUN_CTRL_ADDR, 8'h80);
        tick(2 * PERIOD);
        check("pflag_no_chan", 8'(period_point_flag), 8'h00);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_run();
        t_adc();
        t_same();
        t_pin();
        t_load();
        t_flag();
        give_verdict();
    end
endmodule
